// ==== sim/scpl_pipe_model.sv ====
// Model of the decode pipeline that issues requests to the permission logic
`timescale 1ns/1ps
module scpl_pipe_model (
   // Clock
   input  wire logic                     sys_clk,
   // Instruction side
   output scpl_pkg::scpl_req_t           req,
   input  wire scpl_pkg::scpl_resp_t     resp,
   // Register side
   output scpl_pkg::scpl_msr_req_t       msrReq,
   input  wire scpl_pkg::scpl_msr_resp_t msrResp
);
   // Quiet buses at time zero
   initial
   begin
      req = '0;
      msrReq = '0;
   end

   // One instruction; idle bus then shows the inverse of the request
   task automatic issue(input scpl_pkg::scpl_req_t r, output scpl_pkg::scpl_resp_t a);
      @(posedge sys_clk);
      req <= r;
      @(posedge sys_clk);
      req <= {1'h0, ~r[$bits(r)-2:0]};
      @(negedge sys_clk);
      a = resp;
   endtask

   // One register access, answered at the clock edge that takes it
   task automatic msr(input scpl_pkg::scpl_msr_req_t r, output scpl_pkg::scpl_msr_resp_t a);
      @(posedge sys_clk);
      msrReq <= r;
      @(posedge sys_clk);
      msrReq <= {1'h0, ~r[$bits(r)-2:0]};
      @(negedge sys_clk);
      a = msrResp;
   endtask
endmodule

// ==== sim/tb.sv ====
// Self-checking bench of the state component permission logic
`timescale 1ns/1ps
module tb;
   logic                     sys_clk;
   logic                     rst_n;
   logic                     osEn;
   logic                     ce;
   scpl_pkg::scpl_req_t      req;
   scpl_pkg::scpl_resp_t     resp;
   scpl_pkg::scpl_msr_req_t  msrReq;
   scpl_pkg::scpl_msr_resp_t msrResp;
   logic [63:0]              enMask;
   logic [63:0]              supMask;
   logic [63:0]              compWr;
   scpl_pkg::scpl_resp_t     a;
   scpl_pkg::scpl_msr_resp_t m;
   int                       error_cnt;
   int                       checked;
   int                       cycles;

   // Device and pipeline model
   scpl_state_perm u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .sysCe(ce),
      .osStateMgmtEnable(osEn), .req(req), .resp(resp), .msrReq(msrReq),
      .msrResp(msrResp), .enabledMask(enMask), .supervisorMask(supMask),
      .compWritable(compWr));
   scpl_pipe_model u_pipe (.sys_clk(sys_clk), .req(req), .resp(resp),
      .msrReq(msrReq), .msrResp(msrResp));

   // 125 MHz clock
   initial
   begin
      sys_clk = 1'h0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Hang guard
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One instruction; f is {invalid opcode, protection} fault expected
   task automatic ins(input scpl_pkg::scpl_op_t op, input logic [1:0] current_privilege_level,
      input logic [63:0] msk, input logic [63:0] fm, input logic [1:0] f,
      input logic [63:0] set);
      u_pipe.issue('{1'h1, op, current_privilege_level, msk[63:32], msk[31:0], fm}, a);
      chk({61'h0, a.valid, a.udFault, a.gpFault}, {61'h0, 1'h1, f});
      if (op == scpl_pkg::OP_READ_MASK && f == 2'h0)
         chk(a.readData, set);
      else if (op != scpl_pkg::OP_WRITE_MASK && f == 2'h0)
         chk(a.compSet, set);
   endtask

   task automatic t_reset();
      chk(enMask, scpl_pkg::EN_RESET);
      chk(supMask, scpl_pkg::SUP_RESET);
      chk(compWr, 64'h203);
      ins(scpl_pkg::OP_READ_MASK, 2'h3, 64'h0, 64'h0, 2'h0, 64'h1);
      $display("test reset done");
   endtask

   task automatic t_write();
      ins(scpl_pkg::OP_WRITE_MASK, 2'h3, 64'h7, 64'h0, 2'h1, 64'h0);
      ins(scpl_pkg::OP_WRITE_MASK, 2'h0, 64'h5, 64'h0, 2'h1, 64'h0);
      ins(scpl_pkg::OP_WRITE_MASK, 2'h0, 64'h6, 64'h0, 2'h1, 64'h0);
      ins(scpl_pkg::OP_WRITE_MASK, 2'h0, 64'hF, 64'h0, 2'h1, 64'h0);
      ins(scpl_pkg::OP_WRITE_MASK, 2'h0, 64'h8000_0000_0000_0007, 64'h0, 2'h1, 64'h0);
      chk(enMask, 64'h1);
      ins(scpl_pkg::OP_WRITE_MASK, 2'h0, 64'h7, 64'h0, 2'h0, 64'h0);
      chk(enMask, 64'h7);
      chk(compWr, 64'h207);
      ins(scpl_pkg::OP_READ_MASK, 2'h2, 64'h0, 64'h0, 2'h0, 64'h7);
      $display("test write done");
   endtask

   task automatic t_save();
      scpl_pkg::scpl_op_t ops[4];
      ops = '{scpl_pkg::OP_SAVE_PLAIN, scpl_pkg::OP_SAVE_OPT, scpl_pkg::OP_SAVE_CMP,
         scpl_pkg::OP_RST_PLAIN};
      foreach (ops[i])
         ins(ops[i], 2'h3, 64'h8000_0000_FFFF_FFE5, 64'h0, 2'h0, 64'h5);
      ins(scpl_pkg::OP_SAVE_SUP, 2'h0, '1, 64'h0, 2'h0, 64'h7);
      ins(scpl_pkg::OP_RST_SUP, 2'h0, 64'h8000_0000_0000_0003, 64'h0, 2'h0, 64'h3);
      ins(scpl_pkg::OP_SAVE_SUP, 2'h1, '1, 64'h0, 2'h1, 64'h0);
      ins(scpl_pkg::OP_RST_SUP, 2'h3, '1, 64'h0, 2'h1, 64'h0);
      $display("test save done");
   endtask

   task automatic t_feature();
      ins(scpl_pkg::OP_FEATURE, 2'h3, 64'h0, 64'h4, 2'h0, 64'h0);
      ins(scpl_pkg::OP_FEATURE, 2'h3, 64'h0, 64'hE4, 2'h2, 64'h0);
      ins(scpl_pkg::OP_FEATURE, 2'h3, 64'h0, 64'h203, 2'h0, 64'h0);
      $display("test feature done");
   endtask

   task automatic t_osoff();
      @(posedge sys_clk);
      osEn <= 1'h0;
      @(negedge sys_clk);
      chk(compWr, 64'h203);
      for (int i = 0; i < 8; i++)
         ins(scpl_pkg::scpl_op_t'(i), 2'h0, 64'h3, 64'h0, 2'h2, 64'h0);
      ins(scpl_pkg::OP_FEATURE, 2'h0, 64'h0, 64'h4, 2'h2, 64'h0);
      ins(scpl_pkg::OP_FEATURE, 2'h0, 64'h0, 64'h3, 2'h0, 64'h0);
      chk(enMask, 64'h7);
      @(posedge sys_clk);
      osEn <= 1'h1;
      $display("test os-off done");
   endtask

   task automatic t_msr();
      u_pipe.msr('{1'h1, 1'h0, scpl_pkg::SUP_MSR_INDEX, 64'h0}, m);
      chk({62'h0, m.ack, m.gpFault}, {62'h0, 2'h2});
      chk(m.data, 64'h0);
      u_pipe.msr('{1'h1, 1'h1, scpl_pkg::SUP_MSR_INDEX, 64'h1}, m);
      chk({62'h0, m.ack, m.gpFault}, {62'h0, 2'h3});
      u_pipe.msr('{1'h1, 1'h1, scpl_pkg::SUP_MSR_INDEX, 64'h0}, m);
      chk({62'h0, m.ack, m.gpFault}, {62'h0, 2'h2});
      u_pipe.msr('{1'h1, 1'h0, 32'h0000_0DA1, 64'h0}, m);
      chk({62'h0, m.ack, m.gpFault}, {62'h0, 2'h3});
      chk(supMask, 64'h0);
      $display("test msr done");
   endtask

   // Clock enable low: a request is ignored and the masks are held
   task automatic t_ce();
      @(posedge sys_clk);
      ce <= 1'h0;
      u_pipe.issue('{1'h1, scpl_pkg::OP_WRITE_MASK, 2'h0, 32'h0, 32'h3, 64'h0}, a);
      chk({61'h0, a.valid, a.udFault, a.gpFault}, 64'h0);
      chk(enMask, 64'h7);
      @(posedge sys_clk);
      ce <= 1'h1;
      $display("test clock enable done");
   endtask

   // Reset in mid-run brings back the reset masks
   task automatic t_rerun();
      @(posedge sys_clk);
      rst_n <= 1'h0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'h1;
      @(negedge sys_clk);
      chk(enMask, scpl_pkg::EN_RESET);
      chk(supMask, scpl_pkg::SUP_RESET);
      ins(scpl_pkg::OP_READ_MASK, 2'h1, 64'h0, 64'h0, 2'h0, 64'h1);
      $display("test mid-run reset done");
   endtask

   // Reset, then the scenarios in turn
   initial
   begin
      rst_n = 1'h0;
      osEn = 1'h1;
      ce = 1'h1;
      error_cnt = 0;
      checked = 0;
      cycles = 0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'h1;
      @(negedge sys_clk);
      t_reset();
      t_write();
      t_save();
      t_feature();
      t_osoff();
      t_ce();
      t_msr();
      t_rerun();
      close_out();
   end
endmodule

// ==== src/scpl_mask_gate.sv ====
// Gate of an instruction mask by an allowed-component mask
`timescale 1ns/1ps
module scpl_mask_gate #(
   parameter int W = 64
) (
   // Masks in
   input  wire logic [W-1:0] instrMask,
   input  wire logic [W-1:0] allowMask,
   // Gated set out
   output logic      [W-1:0] gated
);

   assign gated = instrMask & allowMask & {1'b0, {(W-1){1'b1}}};

endmodule

// ==== src/scpl_pkg.sv ====
// Shared constants and types of the state component permission logic
package scpl_pkg;

   // ----------------------------------------------------------------
   // Bitmap layout
   // ----------------------------------------------------------------
   // one bit per component
   localparam int MASK_W = 64;
   localparam int BIT_LEGACY_FP  = 0;
   localparam int BIT_SIMD       = 1;
   localparam int BIT_VEC256     = 2;
   localparam int BIT_VEC512_LO  = 5;
   localparam int BIT_VEC512_HI  = 7;
   localparam int BIT_PKEY       = 9;
   localparam int BIT_SPECIAL    = 63;
   // shapes of components 5, 6 and 7
   localparam int OPMASK_COUNT      = 8;
   localparam int OPMASK_WIDTH      = 64;
   localparam int UPPER_HALF_COUNT  = 16;
   localparam int UPPER_HALF_WIDTH  = 256;
   localparam int HIGH_VEC_COUNT    = 16;
   localparam int HIGH_VEC_WIDTH    = 512;

   // Components 0,1,2,5,6,7,9; everything else in 62:3 is reserved
   localparam logic [63:0] DEFINED_MASK   = 64'h0000_0000_0000_02E7;
   // Components usable without the enable gating
   localparam logic [63:0] UNGATED_MASK   = 64'h0000_0000_0000_0203;
   // Bit that never names a component
   localparam logic [63:0] SPECIAL_MASK   = 64'h8000_0000_0000_0000;
   // Components that only the supervisor mask may name (none defined)
   localparam logic [63:0] SUP_ALLOWED    = 64'h0000_0000_0000_0000;

   // ----------------------------------------------------------------
   // Registers and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] SUP_MSR_INDEX  = 32'h0000_0DA0;
   localparam logic [63:0] EN_RESET       = 64'h0000_0000_0000_0001;
   localparam logic [63:0] SUP_RESET      = 64'h0000_0000_0000_0000;
   localparam logic [1:0]  CPL_KERNEL     = 2'h0;
   localparam logic [1:0]  BAD_VEC_PAIR   = 2'h2;

   // ----------------------------------------------------------------
   // Operations
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_READ_MASK   = 4'h0,
      OP_WRITE_MASK  = 4'h1,
      OP_SAVE_PLAIN  = 4'h2,
      OP_SAVE_OPT    = 4'h3,
      OP_SAVE_CMP    = 4'h4,
      OP_SAVE_SUP    = 4'h5,
      OP_RST_PLAIN   = 4'h6,
      OP_RST_SUP     = 4'h7,
      OP_FEATURE     = 4'h8
   } scpl_op_t;

   typedef struct packed {
      logic          valid;
      scpl_op_t      op;
      logic [1:0]    current_privilege_level;
      logic [31:0]   maskHi;
      logic [31:0]   maskLo;
      logic [63:0]   featureMask;
   } scpl_req_t;

   typedef struct packed {
      logic          valid;
      logic          udFault;
      logic          gpFault;
      logic [63:0]   compSet;
      logic [63:0]   readData;
   } scpl_resp_t;

   typedef struct packed {
      logic          valid;
      logic          write;
      logic [31:0]   index;
      logic [63:0]   data;
   } scpl_msr_req_t;

   typedef struct packed {
      logic          ack;
      logic          gpFault;
      logic [63:0]   data;
   } scpl_msr_resp_t;

endpackage

// ==== src/scpl_state_perm.sv ====
// State component permission logic for the state save/restore family
`timescale 1ns/1ps
module scpl_state_perm (
   // Clock, reset, enable
   input  wire logic                    sys_clk,
   input  wire logic                    rst_n,
   input  wire logic                    sysCe,
   // Control register level
   input  wire logic                    osStateMgmtEnable,
   // Instruction request and answer
   input  wire scpl_pkg::scpl_req_t     req,
   output scpl_pkg::scpl_resp_t         resp,
   // Model-specific register access
   input  wire scpl_pkg::scpl_msr_req_t msrReq,
   output scpl_pkg::scpl_msr_resp_t     msrResp,
   // Mask views and permission levels
   output logic [63:0]                  enabledMask,
   output logic [63:0]                  supervisorMask,
   output logic [63:0]                  compWritable
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [63:0]              enMask;
      logic [63:0]              supMask;
      scpl_pkg::scpl_resp_t     resp;
      scpl_pkg::scpl_msr_resp_t msrResp;
   } scpl_state_t;

   scpl_state_t st_r;
   scpl_state_t st_nxt;

   logic [63:0] instrMask;
   logic [63:0] effEnable;
   logic [63:0] supAllow;
   logic [63:0] gatedPlain;
   logic [63:0] gatedSup;
   logic        privOp;
   logic        badWrite;

   assign instrMask = {req.maskHi, req.maskLo};
   assign effEnable = osStateMgmtEnable ? st_r.enMask : 64'h0000_0000_0000_0000;
   // Sets below use the raw mask: they are only produced with management on
   // supervisor allowance is an OR
   assign supAllow  = st_r.enMask | st_r.supMask;
   assign privOp    = (req.op == scpl_pkg::OP_WRITE_MASK) ||
                      (req.op == scpl_pkg::OP_SAVE_SUP) ||
                      (req.op == scpl_pkg::OP_RST_SUP);
   // Refused values leave the old mask, so no half-set vector pair lands
   // known components form the defined set
   // SIMD and 256-bit vector pair are bits 1-2; bit 2 may not be set without bit 1
   // bit 0 may not be cleared
   assign badWrite  = (|(instrMask & ~scpl_pkg::DEFINED_MASK)) ||
                      !instrMask[scpl_pkg::BIT_LEGACY_FP] ||
                      (instrMask[scpl_pkg::BIT_VEC256:scpl_pkg::BIT_SIMD] ==
                       scpl_pkg::BAD_VEC_PAIR);

   // gates sized to the bitmap width
   // plain set gated by enable mask
   scpl_mask_gate #(
      .W         (scpl_pkg::MASK_W)
   ) u_gate_plain (
      .instrMask (instrMask),
      .allowMask (st_r.enMask),
      .gated     (gatedPlain)
   );

   // supervisor set gated by combined mask
   scpl_mask_gate #(
      .W         (scpl_pkg::MASK_W)
   ) u_gate_sup (
      .instrMask (instrMask),
      .allowMask (supAllow),
      .gated     (gatedSup)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Decode one request per cycle and the register access beside it
   always_comb
   begin
      st_nxt         = st_r;
      st_nxt.resp    = '0;
      st_nxt.msrResp = '0;
      if (req.valid)
      begin
         st_nxt.resp.valid = 1'b1;
         if (req.op == scpl_pkg::OP_FEATURE)
         begin
            st_nxt.resp.udFault = |(req.featureMask & ~scpl_pkg::UNGATED_MASK & ~effEnable);
         end
         else if (!osStateMgmtEnable)
         begin
            st_nxt.resp.udFault = 1'b1;
         end
         else if (privOp && (req.current_privilege_level != scpl_pkg::CPL_KERNEL))
         begin
            st_nxt.resp.gpFault = 1'b1;
         end
         else
         begin
            unique case (req.op)
               scpl_pkg::OP_READ_MASK:
               begin
                  st_nxt.resp.readData = st_r.enMask;
               end
               scpl_pkg::OP_WRITE_MASK:
               begin
                  // mask write, refused values keep old mask
                  if (badWrite)
                  begin
                     st_nxt.resp.gpFault = 1'b1;
                  end
                  else
                  begin
                     st_nxt.enMask = instrMask;
                  end
               end
               scpl_pkg::OP_SAVE_PLAIN,
               scpl_pkg::OP_SAVE_OPT,
               scpl_pkg::OP_SAVE_CMP,
               scpl_pkg::OP_RST_PLAIN:
               begin
                  st_nxt.resp.compSet = gatedPlain;
               end
               scpl_pkg::OP_SAVE_SUP,
               scpl_pkg::OP_RST_SUP:
               begin
                  st_nxt.resp.compSet = gatedSup;
               end
               default:
               begin
                  st_nxt.resp.compSet = 64'h0000_0000_0000_0000;
               end
            endcase
         end
      end
      // Supervisor mask register at its index; other indices fault
      if (msrReq.valid)
      begin
         st_nxt.msrResp.ack = 1'b1;
         if (msrReq.index != scpl_pkg::SUP_MSR_INDEX)
         begin
            st_nxt.msrResp.gpFault = 1'b1;
         end
         else if (msrReq.write)
         begin
            if (|(msrReq.data & ~scpl_pkg::SUP_ALLOWED))
            begin
               st_nxt.msrResp.gpFault = 1'b1;
            end
            else
            begin
               st_nxt.supMask = msrReq.data;
            end
         end
         else
         begin
            st_nxt.msrResp.data = st_r.supMask;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Synchronous reset, frozen while the clock enable is low
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         st_r         <= '0;
         // bit 0 set out of reset
         st_r.enMask  <= scpl_pkg::EN_RESET;
         st_r.supMask <= scpl_pkg::SUP_RESET;
      end
      else if (sysCe)
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs
   assign resp           = st_r.resp;
   assign msrResp        = st_r.msrResp;
   assign enabledMask    = st_r.enMask;
   assign supervisorMask = st_r.supMask;
   // gated components writable only when enabled
   // clearing a bit only drops permission, not contents
   // legacy, SIMD and key state always writable
   assign compWritable   = effEnable | scpl_pkg::UNGATED_MASK;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n || !sysCe);

   logic [63:0] chkPlain;
   logic [63:0] chkSup;
   logic        chkLevel0;
   assign chkPlain  = instrMask & st_r.enMask & ~scpl_pkg::SPECIAL_MASK;
   assign chkSup    = instrMask & (st_r.enMask | st_r.supMask) & ~scpl_pkg::SPECIAL_MASK;
   assign chkLevel0 = req.valid && osStateMgmtEnable && (req.current_privilege_level == scpl_pkg::CPL_KERNEL);

   chk_bit0_held: assert property (st_r.enMask[0])
      else $error("enable bit 0 cleared");
   chk_priv_gp: assert property (req.valid && osStateMgmtEnable && privOp &&
      (req.current_privilege_level != scpl_pkg::CPL_KERNEL) |=> resp.gpFault && !resp.udFault && $stable(st_r.enMask))
      else $error("privilege fault missing or state changed");
   chk_os_off_ud: assert property (req.valid && !osStateMgmtEnable &&
      (req.op != scpl_pkg::OP_FEATURE) |=> resp.udFault && (resp.compSet == 64'h0))
      else $error("family op ran with management off");
   chk_pair_gp: assert property (chkLevel0 && (req.op == scpl_pkg::OP_WRITE_MASK) &&
      (instrMask[2:1] == 2'h2) |=> resp.gpFault ##1 !st_r.enMask[2] || st_r.enMask[1])
      else $error("bad vector pair accepted");
   chk_write_load: assert property (chkLevel0 && (req.op == scpl_pkg::OP_WRITE_MASK) &&
      !badWrite |=> (st_r.enMask == {$past(req.maskHi), $past(req.maskLo)}) && !resp.gpFault)
      else $error("mask write not loaded");
   chk_plain_set: assert property (req.valid && osStateMgmtEnable &&
      ((req.op == scpl_pkg::OP_SAVE_PLAIN) || (req.op == scpl_pkg::OP_RST_PLAIN)) |=>
      resp.compSet == $past(chkPlain))
      else $error("plain set not gated by enable mask");
   chk_sup_set: assert property (chkLevel0 && (req.op == scpl_pkg::OP_SAVE_SUP)
      |=> resp.compSet == $past(chkSup))
      else $error("supervisor set wrong");
   chk_no_bit63: assert property (!resp.compSet[63] && !st_r.enMask[63])
      else $error("bit 63 selected");
   chk_feature_ud: assert property (req.valid && (req.op == scpl_pkg::OP_FEATURE) &&
      !osStateMgmtEnable && |(req.featureMask & 64'h0000_0000_0000_0004) |=> resp.udFault)
      else $error("gated feature ran while disabled");
   chk_off_perm: assert property (!osStateMgmtEnable |->
      compWritable == scpl_pkg::UNGATED_MASK)
      else $error("component writable with management off");

   // Answers judged against the masks held when the request was taken
   chk_opt_cmp_set: assert property (req.valid && osStateMgmtEnable &&
      ((req.op == scpl_pkg::OP_SAVE_OPT) || (req.op == scpl_pkg::OP_SAVE_CMP)) |=>
      resp.compSet == $past(chkPlain))
      else $error("optimized or compacted set wrong");
   chk_rst_sup: assert property (chkLevel0 && (req.op == scpl_pkg::OP_RST_SUP)
      |=> resp.compSet == $past(chkSup))
      else $error("supervisor restore set wrong");
   chk_read_back: assert property (req.valid && osStateMgmtEnable &&
      (req.op == scpl_pkg::OP_READ_MASK) |=> resp.readData == $past(st_r.enMask))
      else $error("mask read returned wrong value");
   chk_ungated_ok: assert property (req.valid && (req.op == scpl_pkg::OP_FEATURE) &&
      ((req.featureMask & ~scpl_pkg::UNGATED_MASK) == 64'h0) |=> resp.valid && !resp.udFault)
      else $error("ungated feature refused");
   chk_vec512_ud: assert property (req.valid && (req.op == scpl_pkg::OP_FEATURE) &&
      (req.featureMask[scpl_pkg::BIT_VEC512_HI:scpl_pkg::BIT_VEC512_LO] == 3'h7) &&
      (st_r.enMask[scpl_pkg::BIT_VEC512_HI:scpl_pkg::BIT_VEC512_LO] != 3'h7) |=> resp.udFault)
      else $error("partly enabled feature ran");
   chk_msr_index: assert property (msrReq.valid &&
      (msrReq.index != scpl_pkg::SUP_MSR_INDEX) |=> msrResp.ack && msrResp.gpFault)
      else $error("unknown register index accepted");
   chk_sup_refuse: assert property (msrReq.valid && msrReq.write &&
      ((msrReq.data & ~scpl_pkg::SUP_ALLOWED) != 64'h0) |=> $stable(st_r.supMask))
      else $error("refused supervisor mask value stored");

   cov_write_ok: cover property (chkLevel0 && (req.op == scpl_pkg::OP_WRITE_MASK) && !badWrite);
   cov_sup_save: cover property (chkLevel0 && (req.op == scpl_pkg::OP_SAVE_SUP) ##1 |resp.compSet);
   cov_priv_gp:  cover property (req.valid && privOp && (req.current_privilege_level != 2'h0) ##1 resp.gpFault);
   cov_feat_ud:  cover property (req.valid && (req.op == scpl_pkg::OP_FEATURE) ##1 resp.udFault);

endmodule
